/* File: hw/lds_bank.v */
// Read-side status, trim, otp window and revision register bank
`timescale 1ns/1ps
`include "lds_regs.vh"
module lds_bank (
  input  wire        CLK_I,
  input  wire        NRST_I,
  input  wire        RD_STB_I,
  input  wire        WR_STB_I,
  input  wire [4:0]  ADDR_I,
  input  wire [9:0]  WDATA_I,
  output reg  [9:0]  RDATA_O,
  output reg         RVALID_O,
  input  wire [7:0]  CH2_ON_TIME_VALUE_I,
  input  wire        CH1_OPEN_LOAD_I,
  input  wire        CH1_SHORT_I,
  input  wire        CH1_OVERCURRENT_I,
  input  wire        CH2_OPEN_LOAD_I,
  input  wire        CH2_SHORT_I,
  input  wire        CH2_OVERCURRENT_I,
  input  wire        FAILSAFE_ACTIVE_I,
  input  wire        HW_RESET_EVENT_I,
  input  wire        LED_CONTROL_INPUT_ONE_I,
  input  wire        LED_CONTROL_INPUT_TWO_I,
  input  wire        SERIAL_ERROR_I,
  input  wire        THERMAL_SHUTDOWN_I,
  input  wire        THERMAL_WARNING_I,
  input  wire        CH1_MIN_ON_TIME_I,
  input  wire        CH2_MIN_ON_TIME_I,
  input  wire        CH1_REGULATOR_STATE_I,
  input  wire        CH2_REGULATOR_STATE_I,
  input  wire        BOOST_UNDERVOLTAGE_I,
  input  wire [1:0]  OTP_OPERATION_I,
  input  wire        OTP_START_I,
  input  wire [1:0]  OTP_ADDR_I,
  input  wire [39:0] OTP_CELLS_I,
  input  wire        TRIM_LOAD_I,
  input  wire [6:0]  CH1_HOT_RANGE_TRIM_I,
  input  wire [6:0]  CH2_HOT_RANGE_TRIM_I,
  input  wire [23:0] DELTA_TRIM_I,
  input  wire [15:0] TEMPCO_TRIM_I,
  input  wire        TEMPCO_USAGE_SELECT_I,
  output reg         OTP_BUSY_O
);
  parameter [0:0] FAMILY_SEL   = 1'b0;
  parameter [1:0] MASK_VERSION = 2'h0;
  parameter [0:0] VARIANT_SEL  = 1'b0;
  parameter [1:0] METAL_TUNE   = 2'h0;

  localparam [2:0] ST_IDLE    = 3'b001;
  localparam [2:0] ST_REFRESH = 3'b010;
  localparam [2:0] ST_ZAP     = 3'b100;

  // Pin inputs pass two flip-flops
  reg  [1:0] in1_sync;
  reg  [1:0] in2_sync;
  wire       ctrl_in1_level = in1_sync[1];
  wire       ctrl_in2_level = in2_sync[1];

  reg  [5:0] led_flags;
  reg  [4:0] chip_flags;
  reg  [1:0] min_on_flags;
  reg  [9:0] otp_window;
  reg  [2:0] state;
  reg  [7:0] op_count;
  reg  [6:0] ch1_hot_range_trim;
  reg  [6:0] ch2_hot_range_trim;
  reg  [23:0] delta_trim;
  reg  [15:0] tempco_trim;
  reg        tempco_usage_select;
  reg  [9:0] next_rdata;
  reg  [7:0] raw;
  reg        read_led;
  reg        read_chip;
  reg        read_reg;
  wire [9:0] word;
  wire [5:0] led_set;
  wire [1:0] min_set;
  wire       otp_fail_set;

  assign led_set = {CH1_OPEN_LOAD_I, CH1_SHORT_I, CH1_OVERCURRENT_I,
                    CH2_OPEN_LOAD_I, CH2_SHORT_I, CH2_OVERCURRENT_I};
  assign min_set = {CH1_MIN_ON_TIME_I, CH2_MIN_ON_TIME_I};
  assign otp_fail_set = (state == ST_ZAP) & BOOST_UNDERVOLTAGE_I;

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      in1_sync <= 2'h0;
      in2_sync <= 2'h0;
    end else begin
      in1_sync <= {in1_sync[0], LED_CONTROL_INPUT_ONE_I};
      in2_sync <= {in2_sync[0], LED_CONTROL_INPUT_TWO_I};
    end
  end

  // Read strobes per clear-on-read register; writes never reach storage
  always @* begin
    read_led  = RD_STB_I & (ADDR_I == `LDS_ADDR_LED_FLT);
    read_chip = RD_STB_I & (ADDR_I == `LDS_ADDR_CHIP_FLT);
    read_reg  = RD_STB_I & (ADDR_I == `LDS_ADDR_REG_STATE);
  end

  // Latched flags: set wins over clear on read
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_led
      always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          led_flags[g] <= 1'b0;
        end else if (led_set[g]) begin
          led_flags[g] <= 1'b1;
        end else if (read_led) begin
          led_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      chip_flags   <= 5'h00;
      min_on_flags <= 2'h0;
    end else begin
      chip_flags <= (read_chip ? 5'h00 : chip_flags)
                    | {otp_fail_set, HW_RESET_EVENT_I, SERIAL_ERROR_I,
                       THERMAL_SHUTDOWN_I, THERMAL_WARNING_I};
      min_on_flags <= (read_reg ? 2'h0 : min_on_flags) | min_set;
    end
  end

  // Trim constants loaded by the factory trim or reset-phase load
  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ch1_hot_range_trim  <= 7'h00;
      ch2_hot_range_trim  <= 7'h00;
      delta_trim          <= 24'h000000;
      tempco_trim         <= 16'h0000;
      tempco_usage_select <= 1'b0;
    end else if (TRIM_LOAD_I) begin
      ch1_hot_range_trim  <= CH1_HOT_RANGE_TRIM_I;
      ch2_hot_range_trim  <= CH2_HOT_RANGE_TRIM_I;
      delta_trim          <= DELTA_TRIM_I;
      tempco_trim         <= TEMPCO_TRIM_I;
      tempco_usage_select <= TEMPCO_USAGE_SELECT_I;
    end
  end

  // Otp operation sequencer
  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state      <= ST_IDLE;
      op_count   <= 8'h00;
      otp_window <= `LDS_OTP_DATA_RST;
      OTP_BUSY_O <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (OTP_START_I && OTP_OPERATION_I == `LDS_OP_REFRESH) begin
            state      <= ST_REFRESH;
            op_count   <= `LDS_OTP_REFRESH_CYC;
            OTP_BUSY_O <= 1'b1;
          end else if (OTP_START_I && OTP_OPERATION_I == `LDS_OP_ZAP) begin
            state      <= ST_ZAP;
            op_count   <= `LDS_OTP_ZAP_CYC;
            OTP_BUSY_O <= 1'b1;
          end
        end
        ST_REFRESH: begin
          op_count <= op_count - 8'h01;
          if (op_count == 8'h01) begin
            state      <= ST_IDLE;
            OTP_BUSY_O <= 1'b0;
            otp_window <= OTP_CELLS_I[OTP_ADDR_I * 10 +: 10];
          end
        end
        ST_ZAP: begin
          op_count <= op_count - 8'h01;
          if (op_count == 8'h01) begin
            state      <= ST_IDLE;
            OTP_BUSY_O <= 1'b0;
          end
        end
        default: begin
          state      <= ST_IDLE;
          OTP_BUSY_O <= 1'b0;
        end
      endcase
    end
  end

  // Read data selection
  always @* begin
    case (ADDR_I)
      `LDS_ADDR_ON_TIME:   raw = CH2_ON_TIME_VALUE_I;
      `LDS_ADDR_LED_FLT:   raw = {2'h0, led_flags};
      `LDS_ADDR_CHIP_FLT:  raw = {chip_flags[4], FAILSAFE_ACTIVE_I, chip_flags[3],
                                  ctrl_in1_level, ctrl_in2_level, chip_flags[2:0]};
      `LDS_ADDR_REG_STATE: raw = {3'h0, OTP_BUSY_O, min_on_flags,
                                  CH1_REGULATOR_STATE_I, CH2_REGULATOR_STATE_I};
      `LDS_ADDR_RNG1:      raw = {1'b0, ch1_hot_range_trim};
      `LDS_ADDR_RNG2:      raw = {1'b0, ch2_hot_range_trim};
      `LDS_ADDR_DELTA1:    raw = delta_trim[7:0];
      `LDS_ADDR_DELTA2:    raw = delta_trim[15:8];
      `LDS_ADDR_DELTA3:    raw = delta_trim[23:16];
      `LDS_ADDR_TC_LO:     raw = tempco_trim[7:0];
      `LDS_ADDR_TC_HI:     raw = tempco_trim[15:8];
      `LDS_ADDR_TC_VER:    raw = {7'h00, tempco_usage_select};
      `LDS_ADDR_SILICON_REVISION:     raw = {2'h0, FAMILY_SEL, MASK_VERSION, VARIANT_SEL, METAL_TUNE};
      default:             raw = 8'h00;
    endcase
    if (ADDR_I == `LDS_ADDR_OTP_DATA) begin
      next_rdata = otp_window;
    end else if (ADDR_I == `LDS_ADDR_SILICON_REVISION || ADDR_I < `LDS_ADDR_ON_TIME) begin
      next_rdata = {2'h0, raw};
    end else begin
      next_rdata = word;
    end
  end

  lds_parity u_parity (
    .data_i (raw),
    .word_o (word)
  );

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O  <= 10'h000;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_STB_I;
      if (RD_STB_I) begin
        RDATA_O <= next_rdata;
      end
    end
  end
endmodule

/* File: inc/lds_regs.vh */
// Register map constants for the LED driver status and trim bank
`ifndef LDS_REGS_VH
`define LDS_REGS_VH
`define LDS_ADDR_ON_TIME   5'h12
`define LDS_ADDR_LED_FLT   5'h13
`define LDS_ADDR_CHIP_FLT  5'h14
`define LDS_ADDR_REG_STATE 5'h15
`define LDS_ADDR_RNG1      5'h16
`define LDS_ADDR_RNG2      5'h17
`define LDS_ADDR_DELTA1    5'h18
`define LDS_ADDR_DELTA2    5'h19
`define LDS_ADDR_DELTA3    5'h1a
`define LDS_ADDR_TC_LO     5'h1b
`define LDS_ADDR_TC_HI     5'h1c
`define LDS_ADDR_TC_VER    5'h1d
`define LDS_ADDR_OTP_DATA  5'h1e
`define LDS_ADDR_SILICON_REVISION     5'h1f
`define LDS_PARITY_BIT     8
`define LDS_BIT_OTP_FAIL   7
`define LDS_BIT_FAILSAFE   6
`define LDS_BIT_HW_RESET   5
`define LDS_BIT_IN1        4
`define LDS_BIT_IN2        3
`define LDS_BIT_SERIAL     2
`define LDS_BIT_TSD        1
`define LDS_BIT_TW         0
`define LDS_BIT_OTP_BUSY   4
`define LDS_OP_REFRESH     2'h1
`define LDS_OP_ZAP         2'h2
`define LDS_OTP_DATA_RST   10'h000
`define LDS_FLAGS_RST      6'h00
`define LDS_OTP_REFRESH_CYC 8'h10
`define LDS_OTP_ZAP_CYC     8'h40
`endif

/* File: hw/lds_parity.v */
// Odd parity word builder
`timescale 1ns/1ps
module lds_parity (
  input  wire [7:0] data_i,
  output wire [9:0] word_o
);
  // Parity bit makes the count of ones over nine bits odd
  assign word_o = {1'b0, ~(^data_i), data_i};
endmodule

/* File: sim/lds_properties.sv */
// Port checks for the status and trim register bank
`timescale 1ns/1ps
module lds_properties (
  input wire       CLK_I,
  input wire       NRST_I,
  input wire       RD_STB_I,
  input wire       WR_STB_I,
  input wire [4:0] ADDR_I,
  input wire [9:0] RDATA_O,
  input wire       RVALID_O,
  input wire [7:0] CH2_ON_TIME_VALUE_I,
  input wire       FAILSAFE_ACTIVE_I,
  input wire       CH1_REGULATOR_STATE_I,
  input wire       OTP_START_I,
  input wire [1:0] OTP_OPERATION_I,
  input wire       OTP_BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_par;
    RVALID_O && $past(ADDR_I) inside {[5'h12:5'h1d]} |-> RDATA_O[8] == ~^RDATA_O[7:0];
  endproperty
  a_par: assert property (p_par) else $error("parity bit wrong");
  property p_rev;
    RVALID_O && $past(ADDR_I) == 5'h1f |-> RDATA_O[9:6] == 4'h0;
  endproperty
  a_rev: assert property (p_rev) else $error("revision top bits set");
  property p_ontime;
    RD_STB_I && ADDR_I == 5'h12 |=> RDATA_O[7:0] == $past(CH2_ON_TIME_VALUE_I);
  endproperty
  a_ontime: assert property (p_ontime) else $error("on-time word wrong");
  property p_live;
    RD_STB_I && ADDR_I == 5'h14 |=> RDATA_O[6] == $past(FAILSAFE_ACTIVE_I);
  endproperty
  a_live: assert property (p_live) else $error("failsafe bit wrong");
  property p_reg;
    RD_STB_I && ADDR_I == 5'h15 |=> RDATA_O[1] == $past(CH1_REGULATOR_STATE_I);
  endproperty
  a_reg: assert property (p_reg) else $error("regulator bit wrong");
  property p_busy;
    OTP_START_I && OTP_OPERATION_I == 2'h1 && !OTP_BUSY_O |=> OTP_BUSY_O [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
  property p_idle;
    !OTP_BUSY_O && !OTP_START_I |=> !OTP_BUSY_O;
  endproperty
  a_idle: assert property (p_idle) else $error("busy without start");
  property p_wr;
    WR_STB_I && !RD_STB_I |=> !RVALID_O;
  endproperty
  a_wr: assert property (p_wr) else $error("write answered");
  cover property (RVALID_O && $past(ADDR_I) == 5'h13);
  cover property ($fell(OTP_BUSY_O));
  cover property (WR_STB_I);
endmodule

/* File: sim/lds_host.sv */
// Host model issuing register reads and writes
`timescale 1ns/1ps
module lds_host (
  input  wire       clk_i,
  input  wire [9:0] rdata_i,
  input  wire       rvalid_i,
  output reg        rd_o,
  output reg        wr_o,
  output reg  [4:0] addr_o,
  output reg  [9:0] wdata_o
);
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 10'h000;
  end
  task rd(input [4:0] a, output [9:0] d);
    begin
      @(posedge clk_i);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rvalid_i ? rdata_i : 10'hxxx;
    end
  endtask
  task wr(input [4:0] a, input [9:0] d);
    begin
      @(posedge clk_i);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
    end
  endtask
endmodule

/* File: sim/tb_led_driver_status_trim_regs.sv */
// Testbench for the status and trim register bank
`timescale 1ns/1ps
module tb_led_driver_status_trim_regs;
  localparam [39:0] CELLS = 40'h9a5c3e71b6;
  localparam [23:0] DT = 24'hc35ae1;
  localparam [15:0] TC = 16'h7b24;
  localparam [6:0]  R1 = 7'h55;
  localparam [6:0]  R2 = 7'h2a;
  localparam [63:0] TR = {8'h01, TC, DT, 1'b0, R2, 1'b0, R1};
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [23:0] fl = 24'h0;
  reg  [7:0]  ont = 8'h00;
  reg         uv = 1'b0;
  reg  [1:0]  op = 2'h0;
  reg         ost = 1'b0;
  reg  [1:0]  oa = 2'h0;
  reg         tl = 1'b0;
  reg         tv = 1'b0;
  reg  [9:0]  d;
  wire        rd, wr, rv, busy;
  wire [4:0]  addr;
  wire [9:0]  wd, rdat;
  integer     i;
  integer     n_errors = 0;
  integer     total_checks = 0;
  always #5 clk = ~clk;
  lds_host i_lds_host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .rd_o(rd), .wr_o(wr), .addr_o(addr),
    .wdata_o(wd));
  lds_bank #(.FAMILY_SEL(1'b1), .MASK_VERSION(2'h2), .VARIANT_SEL(1'b0), .METAL_TUNE(2'h3)) i_lds_bank (
    .CLK_I(clk), .NRST_I(nrst), .RD_STB_I(rd), .WR_STB_I(wr), .ADDR_I(addr), .WDATA_I(wd), .RDATA_O(rdat),
    .RVALID_O(rv), .CH2_ON_TIME_VALUE_I(ont), .CH1_OPEN_LOAD_I(fl[5]), .CH1_SHORT_I(fl[4]),
    .CH1_OVERCURRENT_I(fl[3]), .CH2_OPEN_LOAD_I(fl[2]), .CH2_SHORT_I(fl[1]), .CH2_OVERCURRENT_I(fl[0]),
    .FAILSAFE_ACTIVE_I(fl[14]), .HW_RESET_EVENT_I(fl[13]), .LED_CONTROL_INPUT_ONE_I(fl[12]),
    .LED_CONTROL_INPUT_TWO_I(fl[11]), .SERIAL_ERROR_I(fl[10]), .THERMAL_SHUTDOWN_I(fl[9]),
    .THERMAL_WARNING_I(fl[8]), .CH1_MIN_ON_TIME_I(fl[19]), .CH2_MIN_ON_TIME_I(fl[18]),
    .CH1_REGULATOR_STATE_I(fl[17]), .CH2_REGULATOR_STATE_I(fl[16]), .BOOST_UNDERVOLTAGE_I(uv),
    .OTP_OPERATION_I(op), .OTP_START_I(ost), .OTP_ADDR_I(oa), .OTP_CELLS_I(CELLS), .TRIM_LOAD_I(tl),
    .CH1_HOT_RANGE_TRIM_I(R1), .CH2_HOT_RANGE_TRIM_I(R2), .DELTA_TRIM_I(DT), .TEMPCO_TRIM_I(TC),
    .TEMPCO_USAGE_SELECT_I(tv), .OTP_BUSY_O(busy));
  function [9:0] w(input [7:0] v);
    w = {1'b0, ~^v, v};
  endfunction
  task results;
    begin
      if (n_errors == 0 && total_checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  task rc(input [4:0] a, input [9:0] e);
    begin
      i_lds_host.rd(a, d);
      total_checks = total_checks + 1;
      if (d !== e) begin
        n_errors = n_errors + 1;
        $display("ERROR rdata at %h expected %h seen %h", a, e, d);
      end
    end
  endtask
  // One flag at a time: latched ones clear on read, live ones follow
  task flags(input [1:0] j, input [7:0] used, input [7:0] live);
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        if (used[k]) begin
          @(posedge clk) fl[8*j+k] <= 1'b1;
          @(posedge clk) fl[8*j+k] <= live[k];
          repeat (2) @(posedge clk);
          rc(5'h13 + {3'h0, j}, w(8'h01 << k));
          rc(5'h13 + {3'h0, j}, w(live[k] ? 8'h01 << k : 8'h00));
          @(posedge clk) fl[8*j+k] <= 1'b0;
        end
      end
    end
  endtask
  task otp(input [1:0] o);
    integer k;
    begin
      @(posedge clk) op <= o;
      ost <= 1'b1;
      @(posedge clk) ost <= 1'b0;
      rc(5'h15, w(8'h10));
      for (k = 0; k < 200 && busy; k = k + 1) begin
        @(posedge clk);
        #1;
      end
      if (busy) begin
        n_errors = n_errors + 1;
        results;
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rc(5'h1e, 10'h000);
    rc(5'h16, w(8'h00));
    rc(5'h1f, 10'h033);
    rc(5'h05, 10'h000);
    @(posedge clk) ont <= 8'h81;
    rc(5'h12, w(8'h81));
    @(posedge clk) tv <= 1'b1;
    tl <= 1'b1;
    @(posedge clk) tl <= 1'b0;
    for (i = 0; i < 8; i = i + 1) rc(5'h16 + i[4:0], w(TR[8*i +: 8]));
    i_lds_host.wr(5'h16, 10'h3ff);
    rc(5'h16, w(TR[7:0]));
    for (i = 0; i < 3; i = i + 1) i_lds_host.rd(5'h13 + i[4:0], d);
    flags(2'h0, 8'h3f, 8'h00);
    flags(2'h1, 8'h7f, 8'h58);
    flags(2'h2, 8'h0f, 8'h03);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk) oa <= i[1:0];
      otp(2'h1);
      rc(5'h1e, CELLS[10*i +: 10]);
    end
    @(posedge clk) uv <= 1'b1;
    otp(2'h2);
    @(posedge clk) uv <= 1'b0;
    rc(5'h14, w(8'h80));
    rc(5'h14, w(8'h00));
    results;
  end
endmodule
bind lds_bank lds_properties i_lds_properties (.CLK_I(CLK_I), .NRST_I(NRST_I), .RD_STB_I(RD_STB_I),
  .WR_STB_I(WR_STB_I), .ADDR_I(ADDR_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
  .CH2_ON_TIME_VALUE_I(CH2_ON_TIME_VALUE_I), .FAILSAFE_ACTIVE_I(FAILSAFE_ACTIVE_I),
  .CH1_REGULATOR_STATE_I(CH1_REGULATOR_STATE_I), .OTP_START_I(OTP_START_I),
  .OTP_OPERATION_I(OTP_OPERATION_I), .OTP_BUSY_O(OTP_BUSY_O));
